// file: clk_ctrl.sv
// How it works
// - Reset selects internal RC oscillator as source.
// - Software picks any oscillator as PLL input.
// - Internal RC feeds watchdog and PLL input.
// - Main oscillator feeds CPU and USB PLL.
// - CPU clock is PLL input unless PLL connected.
// - Each peripheral gets its own clock divider.
// - RTC oscillator feeds RTC, PLL input, CPU.
// - Pre-divider N from 1 to 256.
// - Multiplier M from 1 to 32768.
// - Feedback divides by M, detector trims oscillator.
// - Output divider makes CPU and USB clocks.
// - Reset and power-down disable and bypass PLL.
// - Deep-sleep disconnects PLL, zeroes CPU/USB dividers.
// - USB clock from main PLL without USB PLL.
`timescale 1ns/100ps
`default_nettype none
module clk_ctrl (
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  hsel_i,
    input  wire logic [31:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    output logic      [31:0]           hrdata_o,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    input  wire logic                  irc_tick_i,
    input  wire logic                  main_tick_i,
    input  wire logic                  rtc_tick_i,
    input  wire logic                  cco_tick_i,
    input  wire logic                  usb_pll_tick_i,
    input  wire logic                  usb_pll_en_i,
    input  wire logic                  deep_sleep_i,
    input  wire logic                  power_down_i,
    output logic                       cpu_tick_o,
    output logic                       usb_tick_o,
    output logic [clk_ctrl_pkg::NUM_PERIPH-1:0] pclk_tick_o,
    output logic                       wdt_tick_o,
    output logic                       rtc_block_tick_o,
    output logic                       usb_pll_ref_o,
    output logic [15:0]                cco_trim_o,
    output logic                       pll_locked_o
);
    logic                     rst_meta_reg;
    logic                     rst_n;
    clk_ctrl_pkg::bus_state_t bus_reg;
    logic [7:0]               addr_reg;
    logic                     write_reg;
    logic                     ready_reg;
    logic [31:0]              rdata_reg;
    logic [1:0]               src_sel_reg;
    clk_ctrl_pkg::pll_cfg_t   cfg_reg;
    logic                     en_reg;
    logic                     conn_reg;
    logic [7:0]               cpu_div_reg;
    logic [3:0]               usb_div_reg;
    logic [7:0]               pclk_sel_reg;
    logic                     wdt_sel_reg;
    logic                     pend_ref_reg;
    logic                     pend_fb_reg;
    logic [3:0]               match_reg;
    logic                     locked_reg;
    logic [15:0]              trim_reg;
    logic                     cpu_tick_reg;
    logic                     usb_tick_reg;
    logic                     wdt_tick_reg;
    logic                     rtc_tick_reg;
    logic                     usb_ref_reg;
    logic                     ref_div_tick;
    logic                     fb_div_tick;
    logic                     cpu_div_tick;
    logic                     usb_div_tick;

    // Reset is asserted at once but released through two flops.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // Bus decode. Every transfer takes one wait state so read data
    // can come from a flop.
    wire accept   = hsel_i && htrans_i[1] && hready_i;
    wire wr_cycle = (bus_reg == clk_ctrl_pkg::BUS_DATA) && write_reg;
    wire wr_src   = wr_cycle && addr_reg == clk_ctrl_pkg::OFS_SRC_SEL;
    wire wr_cfg   = wr_cycle && addr_reg == clk_ctrl_pkg::OFS_PLL_CFG;
    wire wr_ctrl  = wr_cycle && addr_reg == clk_ctrl_pkg::OFS_PLL_CTRL;
    wire wr_cdiv  = wr_cycle && addr_reg == clk_ctrl_pkg::OFS_CPU_DIV;
    wire wr_udiv  = wr_cycle && addr_reg == clk_ctrl_pkg::OFS_USB_DIV;
    wire wr_psel  = wr_cycle && addr_reg == clk_ctrl_pkg::OFS_PCLK_SEL;
    wire wr_wsel  = wr_cycle && addr_reg == clk_ctrl_pkg::OFS_WDT_SEL;
    wire pll_kill = power_down_i || deep_sleep_i;
    wire pll_active = en_reg && conn_reg && locked_reg;

    wire w_en   = hwdata_i[clk_ctrl_pkg::CTRL_EN_BIT];
    wire w_conn = hwdata_i[clk_ctrl_pkg::CTRL_CONN_BIT];

    clk_ctrl_pkg::pll_stat_t stat;
    assign stat = '{locked: locked_reg, active: pll_active,
                    connect: conn_reg, enable: en_reg};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_reg)
            clk_ctrl_pkg::OFS_SRC_SEL:  rd_mux[1:0]  = src_sel_reg;
            clk_ctrl_pkg::OFS_PLL_CFG:  rd_mux[22:0] = cfg_reg;
            clk_ctrl_pkg::OFS_PLL_CTRL: rd_mux[1:0]  = {conn_reg, en_reg};
            clk_ctrl_pkg::OFS_PLL_STAT: rd_mux[3:0]  = stat;
            clk_ctrl_pkg::OFS_CPU_DIV:  rd_mux[7:0]  = cpu_div_reg;
            clk_ctrl_pkg::OFS_USB_DIV:  rd_mux[3:0]  = usb_div_reg;
            clk_ctrl_pkg::OFS_PCLK_SEL: rd_mux[7:0]  = pclk_sel_reg;
            clk_ctrl_pkg::OFS_WDT_SEL:  rd_mux[0]    = wdt_sel_reg;
            default:                    rd_mux       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_reg   <= clk_ctrl_pkg::BUS_IDLE;
            addr_reg  <= 8'h00;
            write_reg <= 1'b0;
            ready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            case (bus_reg)
                clk_ctrl_pkg::BUS_IDLE: begin
                    if (accept) begin
                        bus_reg   <= clk_ctrl_pkg::BUS_DATA;
                        addr_reg  <= haddr_i[7:0];
                        write_reg <= hwrite_i;
                        ready_reg <= 1'b0;
                    end
                end
                clk_ctrl_pkg::BUS_DATA: begin
                    bus_reg   <= clk_ctrl_pkg::BUS_IDLE;
                    ready_reg <= 1'b1;
                    rdata_reg <= write_reg ? 32'h0000_0000 : rd_mux;
                end
                default: bus_reg <= clk_ctrl_pkg::BUS_IDLE;
            endcase
        end
    end

    // Clock configuration registers.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_sel_reg  <= clk_ctrl_pkg::SRC_SEL_RST;
            cfg_reg      <= clk_ctrl_pkg::PLL_CFG_RST;
            en_reg       <= 1'b0;
            conn_reg     <= 1'b0;
            cpu_div_reg  <= clk_ctrl_pkg::CPU_DIV_RST;
            usb_div_reg  <= clk_ctrl_pkg::USB_DIV_RST;
            pclk_sel_reg <= clk_ctrl_pkg::PCLK_SEL_RST;
            wdt_sel_reg  <= 1'b0;
        end else begin
            if (wr_src) src_sel_reg <= hwdata_i[1:0];
            if (wr_cfg) cfg_reg <= hwdata_i[22:0];
            if (wr_udiv) usb_div_reg <= hwdata_i[3:0];
            if (wr_cdiv) cpu_div_reg <= hwdata_i[7:0];
            if (wr_psel) pclk_sel_reg <= hwdata_i[7:0];
            if (wr_wsel) wdt_sel_reg <= hwdata_i[0];
            if (pll_kill) begin
                en_reg   <= 1'b0;
                conn_reg <= 1'b0;
            end else if (wr_ctrl) begin
                en_reg   <= w_en;
                // Connecting an unlocked loop is ignored.
                conn_reg <= w_conn && w_en && locked_reg;
            end else if (!locked_reg) begin
                conn_reg <= 1'b0;
            end
            if (deep_sleep_i) begin
                cpu_div_reg <= clk_ctrl_pkg::CPU_DIV_RST;
                usb_div_reg <= clk_ctrl_pkg::USB_DIV_RST;
            end
        end
    end

    // Selected oscillator; reserved code 3 falls back to the RC.
    wire sel_tick = (src_sel_reg == clk_ctrl_pkg::SRC_MAIN) ? main_tick_i :
                    (src_sel_reg == clk_ctrl_pkg::SRC_RTC)  ? rtc_tick_i :
                    irc_tick_i;

    freq_div #(.W(8)) u_pre_div (
        .mclk_i       (mclk_i),
        .rst_sync_n_i (rst_n),
        .clr_i        (!en_reg),
        .tick_i       (sel_tick),
        .div_i        (cfg_reg.n_minus1),
        .tick_o       (ref_div_tick)
    );

    freq_div #(.W(15)) u_fb_div (
        .mclk_i       (mclk_i),
        .rst_sync_n_i (rst_n),
        .clr_i        (!en_reg),
        .tick_i       (cco_tick_i),
        .div_i        (cfg_reg.m_minus1),
        .tick_o       (fb_div_tick)
    );

    freq_div #(.W(8)) u_cpu_div (
        .mclk_i       (mclk_i),
        .rst_sync_n_i (rst_n),
        .clr_i        (!en_reg),
        .tick_i       (cco_tick_i),
        .div_i        (cpu_div_reg),
        .tick_o       (cpu_div_tick)
    );

    freq_div #(.W(4)) u_usb_div (
        .mclk_i       (mclk_i),
        .rst_sync_n_i (rst_n),
        .clr_i        (!en_reg),
        .tick_i       (cco_tick_i),
        .div_i        (usb_div_reg),
        .tick_o       (usb_div_tick)
    );

    // Phase-frequency detector. A feedback tick ahead of the reference
    // means the oscillator runs fast, so the trim goes down.
    wire both    = ref_div_tick && fb_div_tick;
    // Two lone ticks of one side on consecutive cycles also break lock, so a stalled
    // oscillator leaves a stale lock flag behind unless reference ticks come every cycle.
    wire fb_late = ref_div_tick && !fb_div_tick &&
                   (pend_fb_reg || pend_ref_reg);
    wire fb_lead = fb_div_tick && !ref_div_tick &&
                   (pend_ref_reg || pend_fb_reg);
    wire late    = fb_div_tick && !ref_div_tick && pend_ref_reg;
    wire early   = ref_div_tick && !fb_div_tick && pend_fb_reg;
    wire trim_up = late && trim_reg != 16'hFFFF;
    wire trim_dn = early && trim_reg != 16'h0000;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_ref_reg <= 1'b0;
            pend_fb_reg  <= 1'b0;
            match_reg    <= 4'h0;
            locked_reg   <= 1'b0;
            trim_reg     <= clk_ctrl_pkg::TRIM_RST;
        end else if (!en_reg) begin
            pend_ref_reg <= 1'b0;
            pend_fb_reg  <= 1'b0;
            match_reg    <= 4'h0;
            locked_reg   <= 1'b0;
        end else begin
            pend_ref_reg <= ref_div_tick && !fb_div_tick && !pend_fb_reg;
            pend_fb_reg  <= fb_div_tick && !ref_div_tick && !pend_ref_reg;
            if (trim_up) trim_reg <= trim_reg + 16'h0001;
            if (trim_dn) trim_reg <= trim_reg - 16'h0001;
            if (both) begin
                if (match_reg != clk_ctrl_pkg::LOCK_MATCHES)
                    match_reg <= match_reg + 4'h1;
                else
                    locked_reg <= 1'b1;
            end else if (fb_late || fb_lead) begin
                match_reg  <= 4'h0;
                locked_reg <= 1'b0;
            end
        end
    end

    // Clock routing; every routed clock leaves through a flop.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_tick_reg <= 1'b0;
            usb_tick_reg <= 1'b0;
            wdt_tick_reg <= 1'b0;
            rtc_tick_reg <= 1'b0;
            usb_ref_reg  <= 1'b0;
        end else begin
            cpu_tick_reg <= pll_active ? cpu_div_tick : sel_tick;
            usb_tick_reg <= usb_pll_en_i ? usb_pll_tick_i :
                            (pll_active && usb_div_tick);
            wdt_tick_reg <= wdt_sel_reg ? rtc_tick_i : irc_tick_i;
            rtc_tick_reg <= rtc_tick_i;
            usb_ref_reg  <= main_tick_i;
        end
    end

    // Each peripheral divides the CPU clock by 1, 2, 4 or 8.
    for (genvar p = 0; p < clk_ctrl_pkg::NUM_PERIPH; p++) begin : g_pclk
        wire [1:0] psel = pclk_sel_reg[2*p +: 2];
        wire [2:0] pdiv = 3'((4'h1 << psel) - 4'h1);
        freq_div #(.W(3)) u_pclk_div (
            .mclk_i       (mclk_i),
            .rst_sync_n_i (rst_n),
            .clr_i        (1'b0),
            .tick_i       (cpu_tick_reg),
            .div_i        (pdiv),
            .tick_o       (pclk_tick_o[p])
        );
    end

    assign hrdata_o         = rdata_reg;
    assign hreadyout_o      = ready_reg;
    assign hresp_o          = 1'b0;
    assign cpu_tick_o       = cpu_tick_reg;
    assign usb_tick_o       = usb_tick_reg;
    assign wdt_tick_o       = wdt_tick_reg;
    assign rtc_block_tick_o = rtc_tick_reg;
    assign usb_pll_ref_o    = usb_ref_reg;
    assign cco_trim_o       = trim_reg;
    assign pll_locked_o     = locked_reg;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    a_cpu_bypass: assert property (!pll_active |=>
        cpu_tick_o == $past(sel_tick)) else $error("cpu clock not bypassed");
    a_pd_kills_pll: assert property (power_down_i |=>
        !en_reg && !conn_reg) else $error("pll alive after power-down");
    a_ds_clears_div: assert property (deep_sleep_i |=>
        cpu_div_reg == 8'h00 && usb_div_reg == 4'h0 && !conn_reg)
        else $error("deep-sleep did not clear dividers");
    a_conn_needs_lock: assert property (
        (conn_reg && !locked_reg) |=> !conn_reg)
        else $error("pll connected without lock");
    a_usb_fallback: assert property (
        (!usb_pll_en_i && !pll_active) |=> !usb_tick_o)
        else $error("usb clock without source");
    a_usb_pll_ref: assert property (##1 usb_pll_ref_o ==
        $past(main_tick_i)) else $error("usb pll ref not main osc");
    a_rtc_route: assert property (##1 rtc_block_tick_o ==
        $past(rtc_tick_i)) else $error("rtc clock not routed");
    a_wdt_irc: assert property (!wdt_sel_reg |=>
        wdt_tick_o == $past(irc_tick_i)) else $error("watchdog not on rc");
    a_lock_drops: assert property (!en_reg |=> !locked_reg)
        else $error("lock held while pll off");
    a_bus_wait: assert property (
        (accept && bus_reg == clk_ctrl_pkg::BUS_IDLE)
        |=> !hreadyout_o ##1 hreadyout_o) else $error("bad wait state");

    c_pll_connected: cover property (pll_active && cpu_tick_o);
    c_lock_read: cover property (locked_reg && accept && !hwrite_i);
    c_ds_active: cover property (pll_active ##1 deep_sleep_i);
endmodule
`default_nettype wire

// file: clk_ctrl_pkg.sv
package clk_ctrl_pkg;
    localparam logic [7:0] OFS_SRC_SEL  = 8'h00;
    localparam logic [7:0] OFS_PLL_CFG  = 8'h04;
    localparam logic [7:0] OFS_PLL_CTRL = 8'h08;
    localparam logic [7:0] OFS_PLL_STAT = 8'h0C;
    localparam logic [7:0] OFS_CPU_DIV  = 8'h10;
    localparam logic [7:0] OFS_USB_DIV  = 8'h14;
    localparam logic [7:0] OFS_PCLK_SEL = 8'h18;
    localparam logic [7:0] OFS_WDT_SEL  = 8'h1C;

    localparam logic [1:0] SRC_IRC  = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_RTC  = 2'h2;

    localparam int NUM_PERIPH = 4;
    localparam int PCLK_SEL_W = 2 * NUM_PERIPH;

    localparam logic [1:0]  SRC_SEL_RST  = 2'h0;
    localparam logic [7:0]  CPU_DIV_RST  = 8'h00;
    localparam logic [3:0]  USB_DIV_RST  = 4'h0;
    localparam logic [7:0]  PCLK_SEL_RST = 8'h00;
    localparam logic [15:0] TRIM_RST     = 16'h8000;
    localparam logic [3:0]  LOCK_MATCHES = 4'h8;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CONN_BIT = 1;
    localparam int CFG_N_LSB     = 0;
    localparam int CFG_M_LSB     = 8;

    typedef struct packed {
        logic [14:0] m_minus1;
        logic [7:0]  n_minus1;
    } pll_cfg_t;

    localparam pll_cfg_t PLL_CFG_RST = '{m_minus1: 15'h0000,
                                         n_minus1: 8'h00};

    typedef struct packed {
        logic locked;
        logic active;
        logic connect;
        logic enable;
    } pll_stat_t;

    typedef enum logic {BUS_IDLE, BUS_DATA} bus_state_t;
endpackage

// file: freq_div.sv
`timescale 1ns/100ps
`default_nettype none
// Divides a stream of one-cycle ticks by div_i + 1.
module freq_div #(
    parameter int W = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_sync_n_i,
    input  wire logic         clr_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] div_i,
    output logic              tick_o
);
    logic [W-1:0] cnt_reg;
    logic         tick_reg;
    wire          wrap = tick_i && (cnt_reg == div_i);

    always_ff @(posedge mclk_i or negedge rst_sync_n_i) begin
        if (!rst_sync_n_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (clr_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= wrap;
            if (tick_i) begin
                cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
            end
        end
    end

    assign tick_o = tick_reg;
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        mclk_i;
    logic        nrst_i;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    wire  logic  hresp;
    wire  logic  [31:0] hrdata;
    logic        internal_rc_osc;
    logic        mtk;
    logic        rtk;
    logic        controlled_oscillator;
    logic        upt;
    logic        upe;
    logic        dsl;
    logic        pdn;
    wire  logic  cpu;
    wire  logic  usb;
    wire  logic  [3:0] pclk;
    wire  logic  wdt;
    wire  logic  rtcb;
    wire  logic  uref;
    wire  logic  [15:0] trim;
    wire  logic  lck;
    int          n_errors;
    int          comparisons;

    clk_ctrl dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .irc_tick_i(internal_rc_osc),
        .main_tick_i(mtk), .rtc_tick_i(rtk), .cco_tick_i(controlled_oscillator),
        .usb_pll_tick_i(upt), .usb_pll_en_i(upe), .deep_sleep_i(dsl),
        .power_down_i(pdn), .cpu_tick_o(cpu), .usb_tick_o(usb),
        .pclk_tick_o(pclk), .wdt_tick_o(wdt), .rtc_block_tick_o(rtcb),
        .usb_pll_ref_o(uref), .cco_trim_o(trim), .pll_locked_o(lck));

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tmo;
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        end_of_test;
    endtask

    // Samples at the falling edge, so the value is what the next rise sees.
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        int   k;
        r = 1'b0;
        k = 0;
        while (!r) begin
            @(negedge mclk_i);
            r = (hready === 1'b1);
            d = hrdata;
            @(posedge mclk_i);
            k++;
            if (k > 40) tmo;
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] d;
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy(d);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(a, 1'b1, d, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] v;
        bus(a, 1'b0, 32'h0, v);
        chk(v & m, e);
    endtask

    task automatic tk(input logic [4:0] v);
        {internal_rc_osc, mtk, rtk, controlled_oscillator, upt} <= v;
    endtask

    // Tolerance of two covers pipeline lag at both ends of the window.
    task automatic cn(input int sel, input int n, input int e);
        logic [9:0] v;
        int         c;
        c = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_i);
            v = {pclk, uref, rtcb, wdt, usb, cpu};
            if (v[sel] === 1'b1) c++;
            @(posedge mclk_i);
        end
        chk({31'h0, (c >= e - 2 && c <= e + 2)}, 32'h1);
    endtask

    task automatic wlock(input logic v);
        int k;
        k = 0;
        while (lck !== v) begin
            @(posedge mclk_i);
            k++;
            if (k > 300) tmo;
        end
    endtask

    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), 32'hFFFFFFFF, 32'h0);
        end
        chk({16'h0, trim}, 32'h00008000);
        chk({31'h0, lck}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        tk(5'b01100);
        cn(0, 32, 0);
        tk(5'b10000);
        cn(0, 32, 32);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
    endtask

    task automatic t_src;
        for (int s = 0; s < 4; s++) begin
            wr(clk_ctrl_pkg::OFS_SRC_SEL, 32'(s));
            rd(clk_ctrl_pkg::OFS_SRC_SEL, 32'h3, 32'(s));
            tk(s == 1 ? 5'b01000 : (s == 2 ? 5'b00100 : 5'b10000));
            cn(0, 32, 32);
        end
        wr(clk_ctrl_pkg::OFS_SRC_SEL, 32'h0);
    endtask

    task automatic t_wdt;
        tk(5'b10000);
        cn(2, 32, 32);
        wr(clk_ctrl_pkg::OFS_WDT_SEL, 32'h1);
        cn(2, 32, 0);
        tk(5'b00100);
        cn(2, 32, 32);
        cn(3, 32, 32);
        tk(5'b01000);
        cn(4, 32, 32);
        wr(clk_ctrl_pkg::OFS_WDT_SEL, 32'h0);
    endtask

    task automatic t_pll;
        tk(5'b10000);
        wr(clk_ctrl_pkg::OFS_PLL_CFG, 32'h007FFFFF);
        rd(clk_ctrl_pkg::OFS_PLL_CFG, 32'hFFFFFFFF,
           32'h007FFFFF);
        wr(clk_ctrl_pkg::OFS_PLL_CFG, 32'h0);
        wr(clk_ctrl_pkg::OFS_CPU_DIV, 32'h3);
        wr(clk_ctrl_pkg::OFS_USB_DIV, 32'h1);
        wr(clk_ctrl_pkg::OFS_PLL_CTRL, 32'h1);
        wr(clk_ctrl_pkg::OFS_PLL_CTRL, 32'h3);
        rd(clk_ctrl_pkg::OFS_PLL_STAT, 32'hB, 32'h1);
        cn(0, 32, 32);
        tk(5'b10010);
        wlock(1'b1);
        wr(clk_ctrl_pkg::OFS_PLL_CTRL, 32'h3);
        rd(clk_ctrl_pkg::OFS_PLL_STAT, 32'hB, 32'hB);
        cn(0, 32, 8);
        cn(1, 32, 16);
        upe <= 1'b1;
        tk(5'b10011);
        cn(1, 32, 32);
        tk(5'b10010);
        cn(1, 32, 0);
        upe <= 1'b0;
        tk(5'b10000);
        wlock(1'b0);
        rd(clk_ctrl_pkg::OFS_PLL_STAT, 32'h2, 32'h0);
        cn(0, 32, 32);
    endtask

    task automatic t_sleep;
        tk(5'b10010);
        wr(clk_ctrl_pkg::OFS_PLL_CTRL, 32'h1);
        wlock(1'b1);
        wr(clk_ctrl_pkg::OFS_PLL_CTRL, 32'h3);
        pdn <= 1'b1;
        repeat (2) @(posedge mclk_i);
        pdn <= 1'b0;
        rd(clk_ctrl_pkg::OFS_PLL_STAT, 32'h3, 32'h0);
        cn(0, 32, 32);
        wr(clk_ctrl_pkg::OFS_PLL_CTRL, 32'h1);
        wr(clk_ctrl_pkg::OFS_CPU_DIV, 32'h5);
        wr(clk_ctrl_pkg::OFS_USB_DIV, 32'h2);
        dsl <= 1'b1;
        repeat (2) @(posedge mclk_i);
        dsl <= 1'b0;
        rd(clk_ctrl_pkg::OFS_PLL_STAT, 32'h3, 32'h0);
        rd(clk_ctrl_pkg::OFS_CPU_DIV, 32'hFFFFFFFF, 32'h0);
        rd(clk_ctrl_pkg::OFS_USB_DIV, 32'hFFFFFFFF, 32'h0);
    endtask

    task automatic t_pclk;
        tk(5'b10000);
        wr(clk_ctrl_pkg::OFS_PCLK_SEL, 32'hE4);
        rd(clk_ctrl_pkg::OFS_PCLK_SEL, 32'hFFFFFFFF, 32'hE4);
        for (int p = 0; p < 4; p++) begin
            cn(5 + p, 64, 64 >> p);
        end
    endtask

    initial begin
        n_errors = 0;
        comparisons = 0;
        nrst_i = 1'b0;
        {hsel, htrans, hwrite, haddr, hwdata} = '0;
        hsize = 3'h2;
        {internal_rc_osc, mtk, rtk, controlled_oscillator, upt, upe, dsl, pdn} = '0;
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        t_reset;
        t_src;
        t_wdt;
        t_pll;
        t_sleep;
        t_pclk;
        end_of_test;
    end
endmodule
`default_nettype wire
